// >>> hdl/spsir_pkg.sv
// constants for the serial port status, mask and receive holding registers
package spsir_pkg;

    localparam int unsigned ADDR_W           = 8;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned EVT_W            = 20;
    localparam int unsigned MODEM_W          = 4;
    localparam int unsigned CHAR_W           = 9;

    // register byte offsets
    localparam logic [7:0] OFS_COMMAND       = 8'h00;
    localparam logic [7:0] OFS_INT_ENABLE    = 8'h08;
    localparam logic [7:0] OFS_INT_DISABLE   = 8'h0C;
    localparam logic [7:0] OFS_INT_MASK      = 8'h10;
    localparam logic [7:0] OFS_STATUS        = 8'h14;
    localparam logic [7:0] OFS_RX_HOLDING    = 8'h18;

    // command register bits
    localparam int unsigned CMD_RST_STATUS   = 0;
    localparam int unsigned CMD_START_IDLE   = 1;
    localparam int unsigned CMD_RST_REPEAT   = 2;
    localparam int unsigned CMD_RST_NEGATIVE_ACK_FLAG     = 3;

    // event bit positions, shared by disable, mask and status
    localparam int unsigned BIT_RX_READY     = 0;
    localparam int unsigned BIT_TX_READY     = 1;
    localparam int unsigned BIT_BREAK        = 2;
    localparam int unsigned BIT_RX_DMA_DONE  = 3;
    localparam int unsigned BIT_TX_DMA_DONE  = 4;
    localparam int unsigned BIT_OVERRUN      = 5;
    localparam int unsigned BIT_FRAMING      = 6;
    localparam int unsigned BIT_PARITY       = 7;
    localparam int unsigned BIT_TIMEOUT      = 8;
    localparam int unsigned BIT_TX_DRAINED   = 9;
    localparam int unsigned BIT_REPEAT_LIMIT = 10;
    localparam int unsigned BIT_TX_BUF_EMPTY = 11;
    localparam int unsigned BIT_RX_BUF_FULL  = 12;
    localparam int unsigned BIT_NEG_ACK      = 13;
    localparam int unsigned BIT_CHANGE_LSB   = 16;
    localparam int unsigned BIT_LEVEL_LSB    = 20;

    // receive holding layout
    localparam int unsigned RHR_SYNC_BIT     = 15;

    // bits 14 and 15 have no event source
    localparam logic [19:0] EVT_VALID        = 20'hF3FFF;
    localparam logic [19:0] MASK_RESET       = 20'h00000;
    localparam logic [8:0]  CHAR_RESET       = 9'h000;
    localparam logic [3:0]  MODEM_RESET      = 4'h0;
    localparam logic [31:0] RDATA_IDLE       = 32'h00000000;

endpackage

// >>> hdl/spsir_top.sv
// status, interrupt mask and receive holding logic of a serial port
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module spsir_top
    import spsir_pkg::*;
(
    input  wire logic                          SYS_CLK_IN,
    input  wire logic                          RST_N_IN,
    input  wire logic [spsir_pkg::ADDR_W-1:0]  REG_ADDR_IN,
    input  wire logic [spsir_pkg::DATA_W-1:0]  REG_WDATA_IN,
    input  wire logic                          REG_WR_IN,
    input  wire logic                          REG_RD_IN,
    output logic      [spsir_pkg::DATA_W-1:0]  REG_RDATA_OUT,
    output logic                               IRQ_OUT,
    output logic                               START_IDLE_TIMER_OUT,
    input  wire logic                          RX_ENABLE_IN,
    input  wire logic                          RX_CHAR_DONE_IN,
    input  wire logic [spsir_pkg::CHAR_W-1:0]  RX_CHAR_IN,
    input  wire logic                          RX_SYNC_KIND_IN,
    input  wire logic                          BREAK_EDGE_IN,
    input  wire logic                          OVERRUN_IN,
    input  wire logic                          FRAME_ERR_IN,
    input  wire logic                          PARITY_ERR_IN,
    input  wire logic                          TIMEOUT_EXPIRE_IN,
    input  wire logic                          TIMEOUT_VALUE_ZERO_IN,
    input  wire logic                          REPEAT_LIMIT_IN,
    input  wire logic                          SMART_CARD_MODE_IN,
    input  wire logic                          NEG_ACK_IN,
    input  wire logic                          TX_ENABLE_IN,
    input  wire logic                          TX_HOLD_FULL_IN,
    input  wire logic                          TX_SHIFT_BUSY_IN,
    input  wire logic                          START_BREAK_PENDING_IN,
    input  wire logic                          RX_DMA_DONE_IN,
    input  wire logic                          TX_DMA_DONE_IN,
    input  wire logic                          TX_DMA_BUF_EMPTY_IN,
    input  wire logic                          RX_DMA_BUF_FULL_IN,
    input  wire logic                          RING_IN,
    input  wire logic                          DATA_SET_READY_IN,
    input  wire logic                          CARRIER_DETECT_IN,
    input  wire logic                          CLEAR_TO_SEND_IN
);

    import spsir_pkg::*;

    typedef struct packed {
        logic [EVT_W-1:0]   mask;
        logic               rx_pending;
        logic [CHAR_W-1:0]  rx_char;
        logic               rx_sync;
        logic               brk;
        logic               ovr;
        logic               frm;
        logic               par;
        logic               tmo;
        logic               rep;
        logic               nak;
        logic [MODEM_W-1:0] pin_s1;
        logic [MODEM_W-1:0] pin_s2;
        logic [MODEM_W-1:0] pin_s3;
        logic [MODEM_W-1:0] chg;
        logic [DATA_W-1:0]  rdata;
        logic               irq;
        logic               idle_start;
    } spsir_state_s;

    spsir_state_s st_reg;
    spsir_state_s st_next;

    logic [EVT_W-1:0]   flag_vec;
    logic [MODEM_W-1:0] pin_raw;
    logic               wr_cmd;
    logic               rd_status;
    logic               rd_hold;
    logic               cmd_rst_status;
    logic               cmd_start_idle;
    logic               cmd_rst_repeat;
    logic               cmd_rst_negative_ack_flag;

    // order matches status bits 20..23 and 16..19
    assign pin_raw        = {CLEAR_TO_SEND_IN, CARRIER_DETECT_IN, DATA_SET_READY_IN, RING_IN};

    assign wr_cmd         = REG_WR_IN && (REG_ADDR_IN == OFS_COMMAND);
    assign rd_status      = REG_RD_IN && (REG_ADDR_IN == OFS_STATUS);
    assign rd_hold        = REG_RD_IN && (REG_ADDR_IN == OFS_RX_HOLDING);
    assign cmd_rst_status = wr_cmd && REG_WDATA_IN[CMD_RST_STATUS];
    assign cmd_start_idle = wr_cmd && REG_WDATA_IN[CMD_START_IDLE];
    assign cmd_rst_repeat = wr_cmd && REG_WDATA_IN[CMD_RST_REPEAT];
    assign cmd_rst_negative_ack_flag   = wr_cmd && REG_WDATA_IN[CMD_RST_NEGATIVE_ACK_FLAG];

    // live view of every event source as status reports it
    always_comb
    begin
        flag_vec                   = '0;
        flag_vec[BIT_RX_READY]     = st_reg.rx_pending && RX_ENABLE_IN;
        flag_vec[BIT_TX_READY]     = TX_ENABLE_IN && !TX_HOLD_FULL_IN
                                     && !START_BREAK_PENDING_IN;
        flag_vec[BIT_BREAK]        = st_reg.brk;
        flag_vec[BIT_RX_DMA_DONE]  = RX_DMA_DONE_IN;
        flag_vec[BIT_TX_DMA_DONE]  = TX_DMA_DONE_IN;
        flag_vec[BIT_OVERRUN]      = st_reg.ovr;
        flag_vec[BIT_FRAMING]      = st_reg.frm;
        flag_vec[BIT_PARITY]       = st_reg.par;
        flag_vec[BIT_TIMEOUT]      = st_reg.tmo && !TIMEOUT_VALUE_ZERO_IN;
        flag_vec[BIT_TX_DRAINED]   = TX_ENABLE_IN && !TX_HOLD_FULL_IN && !TX_SHIFT_BUSY_IN;
        flag_vec[BIT_REPEAT_LIMIT] = st_reg.rep;
        flag_vec[BIT_TX_BUF_EMPTY] = TX_DMA_BUF_EMPTY_IN;
        flag_vec[BIT_RX_BUF_FULL]  = RX_DMA_BUF_FULL_IN;
        flag_vec[BIT_NEG_ACK]      = st_reg.nak;
        flag_vec[BIT_CHANGE_LSB +: MODEM_W] = st_reg.chg;
    end

    always_comb
    begin
        st_next = st_reg;

        // modem pins are asynchronous: two flops, then one more for edge detect
        st_next.pin_s1 = pin_raw;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;

        // set wins over clear on every sticky flag
        st_next.chg = ((rd_status ? MODEM_RESET : st_reg.chg)
                       | (st_reg.pin_s2 ^ st_reg.pin_s3));

        if (rd_hold)
        begin
            st_next.rx_pending = 1'b0;
        end
        // latched even while the receiver is off, shown once it returns
        if (RX_CHAR_DONE_IN)
        begin
            st_next.rx_pending = 1'b1;
            st_next.rx_char    = RX_CHAR_IN;
            st_next.rx_sync    = RX_SYNC_KIND_IN;
        end

        st_next.brk = (st_reg.brk && !cmd_rst_status) || BREAK_EDGE_IN;
        st_next.ovr = (st_reg.ovr && !cmd_rst_status) || OVERRUN_IN;
        st_next.frm = (st_reg.frm && !cmd_rst_status) || FRAME_ERR_IN;
        st_next.par = (st_reg.par && !cmd_rst_status) || PARITY_ERR_IN;
        // zero timeout value keeps the flag from ever being armed
        st_next.tmo = ((st_reg.tmo && !cmd_start_idle) || TIMEOUT_EXPIRE_IN)
                      && !TIMEOUT_VALUE_ZERO_IN;
        st_next.rep = (st_reg.rep && !(cmd_rst_repeat && SMART_CARD_MODE_IN))
                      || REPEAT_LIMIT_IN;
        st_next.nak = (st_reg.nak && !cmd_rst_negative_ack_flag) || NEG_ACK_IN;

        // counter restart is the timer's job; this is its one-cycle trigger
        st_next.idle_start = cmd_start_idle;

        if (REG_WR_IN && (REG_ADDR_IN == OFS_INT_ENABLE))
        begin
            st_next.mask = st_reg.mask | (REG_WDATA_IN[EVT_W-1:0] & EVT_VALID);
        end
        else if (REG_WR_IN && (REG_ADDR_IN == OFS_INT_DISABLE))
        begin
            st_next.mask = st_reg.mask & ~REG_WDATA_IN[EVT_W-1:0];
        end

        // read data valid only in the cycle after the strobe
        st_next.rdata = RDATA_IDLE;
        if (REG_RD_IN)
        begin
            if (REG_ADDR_IN == OFS_INT_MASK)
            begin
                st_next.rdata[EVT_W-1:0] = st_reg.mask;
            end
            else if (REG_ADDR_IN == OFS_STATUS)
            begin
                st_next.rdata[EVT_W-1:0] = flag_vec;
                st_next.rdata[BIT_LEVEL_LSB +: MODEM_W] = st_reg.pin_s2;
            end
            else if (REG_ADDR_IN == OFS_RX_HOLDING)
            begin
                st_next.rdata[CHAR_W-1:0]   = st_reg.rx_char;
                st_next.rdata[RHR_SYNC_BIT] = st_reg.rx_sync;
            end
            else
            begin
                // write-only and unmapped offsets read as zero
                st_next.rdata = RDATA_IDLE;
            end
        end

        st_next.irq = |(flag_vec & st_reg.mask);
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            st_reg.mask       <= MASK_RESET;
            st_reg.rx_pending <= 1'b0;
            st_reg.rx_char    <= CHAR_RESET;
            st_reg.rx_sync    <= 1'b0;
            st_reg.brk        <= 1'b0;
            st_reg.ovr        <= 1'b0;
            st_reg.frm        <= 1'b0;
            st_reg.par        <= 1'b0;
            st_reg.tmo        <= 1'b0;
            st_reg.rep        <= 1'b0;
            st_reg.nak        <= 1'b0;
            st_reg.pin_s1     <= MODEM_RESET;
            st_reg.pin_s2     <= MODEM_RESET;
            st_reg.pin_s3     <= MODEM_RESET;
            st_reg.chg        <= MODEM_RESET;
            st_reg.rdata      <= RDATA_IDLE;
            st_reg.irq        <= 1'b0;
            st_reg.idle_start <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA_OUT        = st_reg.rdata;
    assign IRQ_OUT              = st_reg.irq;
    assign START_IDLE_TIMER_OUT = st_reg.idle_start;

    // checks on the design's own state

    property p_disable_clears;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (REG_WR_IN && REG_ADDR_IN == OFS_INT_DISABLE && REG_WDATA_IN[BIT_OVERRUN])
        |=> !st_reg.mask[BIT_OVERRUN];
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disable write left mask bit set");

    property p_mask_read;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (REG_RD_IN && REG_ADDR_IN == OFS_INT_MASK)
        |=> REG_RDATA_OUT == {12'h000, $past(st_reg.mask)};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read differs from mask");

    property p_rx_ready_read;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        rd_status |=> REG_RDATA_OUT[BIT_RX_READY] == $past(st_reg.rx_pending && RX_ENABLE_IN);
    endproperty
    a_rx_ready_read: assert property (p_rx_ready_read)
        else $error("receive ready wrong on status read");

    property p_hold_clears_ready;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (rd_hold && !RX_CHAR_DONE_IN) |=> !st_reg.rx_pending && !flag_vec[BIT_RX_READY];
    endproperty
    a_hold_clears_ready: assert property (p_hold_clears_ready)
        else $error("holding read did not clear receive ready");

    property p_char_kept_while_off;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (RX_CHAR_DONE_IN && !RX_ENABLE_IN) |=> st_reg.rx_pending;
    endproperty
    a_char_kept_while_off: assert property (p_char_kept_while_off)
        else $error("character lost while receiver off");

    property p_overrun_sticky;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (OVERRUN_IN ##1 !cmd_rst_status) |=> st_reg.ovr;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky)
        else $error("overrun flag did not hold");

    property p_timeout_zero;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        TIMEOUT_VALUE_ZERO_IN |-> !flag_vec[BIT_TIMEOUT];
    endproperty
    a_timeout_zero: assert property (p_timeout_zero)
        else $error("timeout flag set with zero value");

    property p_drained_read;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        rd_status |=> REG_RDATA_OUT[BIT_TX_DRAINED]
                      == $past(TX_ENABLE_IN && !TX_HOLD_FULL_IN && !TX_SHIFT_BUSY_IN);
    endproperty
    a_drained_read: assert property (p_drained_read)
        else $error("transmitter drained wrong");

    property p_repeat_needs_smart;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (cmd_rst_repeat && !SMART_CARD_MODE_IN && st_reg.rep) |=> st_reg.rep;
    endproperty
    a_repeat_needs_smart: assert property (p_repeat_needs_smart)
        else $error("repetition flag cleared outside smart-card mode");

    property p_modem_change;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (st_reg.pin_s2[3] != st_reg.pin_s3[3]) |=> st_reg.chg[3];
    endproperty
    a_modem_change: assert property (p_modem_change)
        else $error("pin change not flagged");

    // a read with no new edge in the same cycle must leave all change flags clear
    property p_change_clears;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        (rd_status && st_reg.pin_s2 == st_reg.pin_s3) |=> st_reg.chg == MODEM_RESET;
    endproperty
    a_change_clears: assert property (p_change_clears)
        else $error("status read did not clear change flags");

    property p_hold_read;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        rd_hold |=> REG_RDATA_OUT == {16'h0000, $past(st_reg.rx_sync), 6'h00, $past(st_reg.rx_char)};
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("receive holding layout wrong");

    property p_levels_read;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        rd_status |=> REG_RDATA_OUT[BIT_LEVEL_LSB +: MODEM_W] == $past(st_reg.pin_s2);
    endproperty
    a_levels_read: assert property (p_levels_read)
        else $error("modem levels wrong on status read");

    property p_irq_follows;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        1'b1 ##1 1'b1 |-> IRQ_OUT == $past(|(flag_vec & st_reg.mask));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not match flags and mask");

endmodule

// >>> tb/spsir_far_model.sv
// far-side model: remote terminal sending characters and moving modem lines
`timescale 1ns/1ps
module spsir_far_model
(
    input  wire logic       clk_in,
    output logic            char_done_out,
    output logic [8:0]      char_out,
    output logic            sync_kind_out,
    output logic [3:0]      modem_out
);
    initial
    begin
        {char_done_out, char_out, sync_kind_out, modem_out} = '0;
    end
    task automatic send_char(input logic [8:0] ch, input logic kind);
        @(posedge clk_in);
        char_done_out <= 1'b1;
        char_out      <= ch;
        sync_kind_out <= kind;
        @(posedge clk_in);
        char_done_out <= 1'b0;
        // stale bus must not pass for a latched character
        char_out      <= ~ch;
        sync_kind_out <= ~kind;
    endtask
    task automatic set_modem(input logic [3:0] lv);
        @(posedge clk_in);
        modem_out <= lv;
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the serial port status and mask block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    import spsir_pkg::*;
    logic        clk, rst_n, wr, rd, irq, idle_pulse, rx_en, tv_zero, smart, cdone, sync;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [6:0]  ev;
    logic [3:0]  tx, dma, modem;
    logic [8:0]  ch;
    int          num_errors, total_checks;

    spsir_top u_spsir_top (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq), .START_IDLE_TIMER_OUT(idle_pulse),
        .RX_ENABLE_IN(rx_en), .RX_CHAR_DONE_IN(cdone), .RX_CHAR_IN(ch), .RX_SYNC_KIND_IN(sync),
        .BREAK_EDGE_IN(ev[0]), .OVERRUN_IN(ev[1]), .FRAME_ERR_IN(ev[2]), .PARITY_ERR_IN(ev[3]),
        .TIMEOUT_EXPIRE_IN(ev[4]), .TIMEOUT_VALUE_ZERO_IN(tv_zero), .REPEAT_LIMIT_IN(ev[5]),
        .SMART_CARD_MODE_IN(smart), .NEG_ACK_IN(ev[6]), .TX_ENABLE_IN(tx[0]), .TX_HOLD_FULL_IN(tx[1]),
        .TX_SHIFT_BUSY_IN(tx[2]), .START_BREAK_PENDING_IN(tx[3]), .RX_DMA_DONE_IN(dma[0]),
        .TX_DMA_DONE_IN(dma[1]), .TX_DMA_BUF_EMPTY_IN(dma[2]), .RX_DMA_BUF_FULL_IN(dma[3]),
        .RING_IN(modem[0]), .DATA_SET_READY_IN(modem[1]), .CARRIER_DETECT_IN(modem[2]),
        .CLEAR_TO_SEND_IN(modem[3]));
    spsir_far_model u_spsir_far_model (.clk_in(clk), .char_done_out(cdone), .char_out(ch),
        .sync_kind_out(sync), .modem_out(modem));

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata & m, e)
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev    <= '0;
    endtask

    task automatic t_regs();
        chk_reg(OFS_STATUS, 32'hFFFFFFFF, 32'h0);
        chk_reg(OFS_INT_MASK, 32'hFFFFFFFF, 32'h0);
        wreg(OFS_INT_ENABLE, 32'hFFFFFFFF);
        chk_reg(OFS_INT_MASK, 32'hFFFFFFFF, 32'h000F3FFF);
        wreg(OFS_INT_DISABLE, 32'h0);
        chk_reg(OFS_INT_MASK, 32'hFFFFFFFF, 32'h000F3FFF);
        wreg(OFS_INT_DISABLE, 32'h00080021);
        chk_reg(OFS_INT_MASK, 32'hFFFFFFFF, 32'h00073FDE);
        chk_reg(OFS_INT_DISABLE, 32'hFFFFFFFF, 32'h0);
        chk_reg(8'h40, 32'hFFFFFFFF, 32'h0);
        $display("done t_regs");
    endtask
    task automatic t_sticky();
        int unsigned pos[4] = '{BIT_BREAK, BIT_OVERRUN, BIT_FRAMING, BIT_PARITY};
        wreg(OFS_INT_DISABLE, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++)
        begin
            wreg(OFS_INT_ENABLE, 32'h1 << pos[i]);
            pulse(i);
            chk_reg(OFS_STATUS, 32'h3FFF, 32'h1 << pos[i]);
            `CHK(irq, 1'b1)
            wreg(OFS_COMMAND, 32'h1 << CMD_RST_STATUS);
            chk_reg(OFS_STATUS, 32'h3FFF, 32'h0);
            `CHK(irq, 1'b0)
            wreg(OFS_INT_DISABLE, 32'h1 << pos[i]);
        end
        $display("done t_sticky");
    endtask
    task automatic t_cmds();
        pulse(4);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h1 << BIT_TIMEOUT);
        wreg(OFS_COMMAND, 32'h1 << CMD_START_IDLE);
        #1;
        `CHK(idle_pulse, 1'b1)
        @(posedge clk);
        #1;
        `CHK(idle_pulse, 1'b0)
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h0);
        @(posedge clk);
        tv_zero <= 1'b1;
        pulse(4);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h0);
        pulse(5);
        wreg(OFS_COMMAND, 32'h1 << CMD_RST_REPEAT);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h1 << BIT_REPEAT_LIMIT);
        @(posedge clk);
        smart <= 1'b1;
        wreg(OFS_COMMAND, 32'h1 << CMD_RST_REPEAT);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h0);
        pulse(6);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h1 << BIT_NEG_ACK);
        wreg(OFS_COMMAND, 32'h1 << CMD_RST_NEGATIVE_ACK_FLAG);
        chk_reg(OFS_STATUS, 32'h3FFF, 32'h0);
        $display("done t_cmds");
    endtask
    task automatic t_rx();
        u_spsir_far_model.send_char(9'h1A5, 1'b1);
        chk_reg(OFS_STATUS, 32'h1, 32'h1);
        chk_reg(OFS_RX_HOLDING, 32'hFFFFFFFF, 32'h000081A5);
        chk_reg(OFS_STATUS, 32'h1, 32'h0);
        @(posedge clk);
        rx_en <= 1'b0;
        u_spsir_far_model.send_char(9'h05A, 1'b0);
        chk_reg(OFS_STATUS, 32'h1, 32'h0);
        @(posedge clk);
        rx_en <= 1'b1;
        chk_reg(OFS_STATUS, 32'h1, 32'h1);
        chk_reg(OFS_RX_HOLDING, 32'hFFFFFFFF, 32'h0000005A);
        $display("done t_rx");
    endtask
    task automatic t_live();
        logic [3:0] v;
        for (int i = 0; i < 16; i++)
        begin
            v = i[3:0];
            @(posedge clk);
            tx  <= v;
            dma <= v;
            chk_reg(OFS_STATUS, 32'h1A1A, {19'h0, v[3], v[2], 1'b0, v[0] & ~v[1] & ~v[2], 4'h0, v[1], v[0],
                1'b0, v[0] & ~v[1] & ~v[3], 1'b0});
        end
        $display("done t_live");
    endtask
    task automatic t_modem();
        u_spsir_far_model.set_modem(4'b1011);
        repeat (5) @(posedge clk);
        chk_reg(OFS_STATUS, 32'h00FF0000, 32'h00BB0000);
        chk_reg(OFS_STATUS, 32'h00FF0000, 32'h00B00000);
        $display("done t_modem");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #2000000;
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end
    initial
    begin
        {rst_n, wr, rd, tv_zero, smart, ev, tx, dma, addr, wdata} = '0;
        rx_en = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sticky();
        t_cmds();
        t_rx();
        t_live();
        t_modem();
        end_sim();
    end
endmodule
